/* File: rtl/aaom_pkg.sv */
// constants, field layouts and carrier types for the arming/offset monitor
// assumes a 100 MHz core clock and a serial master using mode 0, MSB first
package aaom_pkg;

	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned CLK_RATE_MHZ = 1000 / CLK_PERIOD_NS;

	// sample period of the processing chain and the half-period delay
	localparam int unsigned SAMPLE_PERIOD_NS = 8000;
	localparam int unsigned HALF_SAMPLE_CYCLES =
		SAMPLE_PERIOD_NS / 2 / CLK_PERIOD_NS;

	// offset watch hold-off after reset, 2.1 s
	localparam int unsigned OFFSET_HOLD_MS = 2100;
	localparam int unsigned OFFSET_HOLD_CYCLES =
		OFFSET_HOLD_MS * (1000000 / CLK_PERIOD_NS);

	// stretch timebase tick and load values in ticks
	localparam int unsigned STRETCH_TICK_NS = 1000;
	localparam int unsigned STRETCH_TICK_CYCLES =
		STRETCH_TICK_NS / CLK_PERIOD_NS;
	localparam logic [15:0] STRETCH_LOAD_1 = 16'h0200;
	localparam logic [15:0] STRETCH_LOAD_2 = 16'h0400;
	localparam logic [15:0] STRETCH_LOAD_3 = 16'h0800;

	// pulse-code output rate
	localparam int unsigned PCM_RATE_MHZ = 8;

	// serial command layout
	localparam int unsigned CMD_WIDTH = 16;
	localparam logic [3:0] CMD_LAST_BIT = 4'hF;

	// reset values
	localparam logic CS_N_RESET = 1'b1;
	localparam logic [3:0] ARM_COUNT_RESET = 4'h0;
	localparam logic [15:0] STRETCH_RESET = 16'h0000;

	typedef enum logic [1:0] {
		AAOM_ARM_OFF,
		AAOM_ARM_AVERAGE,
		AAOM_ARM_COUNT,
		AAOM_ARM_UNFILTERED
	} aaom_arm_mode_t;

	// device_config_register fields
	typedef struct packed {
		logic offset_watch_enable;
		aaom_arm_mode_t arm_mode;
		logic arm_active_low;
		logic pcm_enable;
	} aaom_dev_cfg_t;

	// arm_config_register fields
	typedef struct packed {
		logic [1:0] arm_window_size;
		logic [1:0] arm_stretch_select;
	} aaom_arm_cfg_t;

	// arm_threshold_register pair, two's complement
	typedef struct packed {
		logic [7:0] pos;
		logic [7:0] neg;
	} aaom_arm_thr_t;

	// offset_limit pair, same width as the correction value
	typedef struct packed {
		logic [9:0] pos;
		logic [9:0] neg;
	} aaom_offset_limit_t;

endpackage

/* File: rtl/aaom_monitor.sv */
// arming comparator, offset watch, interpolation and pulse-code output
// assumes the serial clock idles low while CS is high and that config
// inputs come from logic on i_clock
module aaom_monitor #(
	parameter int unsigned SAMPLE_W = 10,
	parameter int unsigned OFFSET_HOLD = aaom_pkg::OFFSET_HOLD_CYCLES,
	parameter int unsigned HALF_SAMPLE = aaom_pkg::HALF_SAMPLE_CYCLES
) (
	input wire logic i_clock,
	input wire logic i_srst,
	input wire logic i_spi_sclk,
	input wire logic i_spi_cs_n,
	input wire logic i_spi_mosi,
	input wire logic [SAMPLE_W-1:0] i_sample,
	input wire logic i_sample_valid,
	input wire logic [9:0] i_offset_corr,
	input wire logic i_offset_update,
	input wire logic i_self_test,
	input wire aaom_pkg::aaom_offset_limit_t i_offset_limit,
	input wire aaom_pkg::aaom_dev_cfg_t i_device_config_register,
	input wire aaom_pkg::aaom_arm_cfg_t i_arm_config_register,
	input wire aaom_pkg::aaom_arm_thr_t i_arm_threshold_register,
	input wire logic i_arm_error,
	output logic [SAMPLE_W-1:0] o_accel_data,
	output logic o_accel_valid,
	output logic o_offset_over_range,
	output logic o_arm,
	output logic o_pcm
);

	if (SAMPLE_W < 9 || SAMPLE_W > 16) begin : g_bad_width
		$error("SAMPLE_W must lie between 9 and 16");
	end
	if (OFFSET_HOLD < 1 || HALF_SAMPLE < 1) begin : g_bad_count
		$error("hold and half-sample counts must be at least one");
	end

	localparam int unsigned SUM_W = SAMPLE_W + 3;

	function automatic logic [3:0] window_k(input logic [1:0] sel);
		window_k = 4'h1 << sel;
	endfunction

	function automatic logic beyond(input logic [SAMPLE_W-1:0] s,
			input aaom_pkg::aaom_arm_thr_t thr);
		logic signed [7:0] s8;
		s8 = s[SAMPLE_W-1 -: 8];
		beyond = (s8 >= $signed(thr.pos)) || (s8 <= $signed(thr.neg));
	endfunction

	function automatic logic [15:0] stretch_load(input logic [1:0] sel);
		case (sel)
			2'h1: stretch_load = aaom_pkg::STRETCH_LOAD_1;
			2'h2: stretch_load = aaom_pkg::STRETCH_LOAD_2;
			2'h3: stretch_load = aaom_pkg::STRETCH_LOAD_3;
			default: stretch_load = aaom_pkg::STRETCH_RESET;
		endcase
	endfunction

	// link side: clocked by the serial clock; bit count and first bit held clear while CS is high
	logic [3:0] link_bit_reg;
	logic link_first_reg;
	logic link_tgl_reg;

	always_ff @(posedge i_spi_sclk or posedge i_spi_cs_n) begin
		if (i_spi_cs_n) begin
			link_bit_reg <= 4'h0;
			link_first_reg <= 1'b0;
		end else begin
			link_bit_reg <= link_bit_reg + 4'h1;
			if (link_bit_reg == 4'h0) begin
				link_first_reg <= i_spi_mosi;
			end
		end
	end

	// toggle marks a complete acceleration request; short frames drop it
	always_ff @(posedge i_spi_sclk or posedge i_srst) begin
		if (i_srst) begin
			link_tgl_reg <= 1'b0;
		end else if (!i_spi_cs_n && link_bit_reg == aaom_pkg::CMD_LAST_BIT
				&& link_first_reg) begin
			link_tgl_reg <= ~link_tgl_reg;
		end
	end

	// crossing into the core domain
	logic cs_s1_reg;
	logic cs_s2_reg;
	logic cs_prev_reg;
	logic tgl_s1_reg;
	logic tgl_s2_reg;
	logic tgl_prev_reg;

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			cs_s1_reg <= aaom_pkg::CS_N_RESET;
			cs_s2_reg <= aaom_pkg::CS_N_RESET;
			cs_prev_reg <= aaom_pkg::CS_N_RESET;
			tgl_s1_reg <= 1'b0;
			tgl_s2_reg <= 1'b0;
			tgl_prev_reg <= 1'b0;
		end else begin
			cs_s1_reg <= i_spi_cs_n;
			cs_s2_reg <= cs_s1_reg;
			cs_prev_reg <= cs_s2_reg;
			tgl_s1_reg <= link_tgl_reg;
			tgl_s2_reg <= tgl_s1_reg;
			tgl_prev_reg <= tgl_s2_reg;
		end
	end

	logic cs_fall;
	logic cs_rise;
	logic req_pending_reg;
	logic resp_active_reg;
	logic resp_start;

	assign cs_fall = cs_prev_reg & ~cs_s2_reg;
	assign cs_rise = ~cs_prev_reg & cs_s2_reg;
	assign resp_start = cs_fall & req_pending_reg;

	// a request arriving in the consuming cycle stays pending
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			req_pending_reg <= 1'b0;
		end else if (tgl_s2_reg != tgl_prev_reg) begin
			req_pending_reg <= 1'b1;
		end else if (cs_fall) begin
			req_pending_reg <= 1'b0;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			resp_active_reg <= 1'b0;
		end else if (resp_start) begin
			resp_active_reg <= 1'b1;
		end else if (cs_rise) begin
			resp_active_reg <= 1'b0;
		end
	end

	// interpolation: midpoint at once, true sample half a period later
	logic [SAMPLE_W-1:0] pend_reg;
	logic [SAMPLE_W-1:0] interp_reg;
	logic [31:0] half_cnt_reg;
	logic half_run_reg;
	logic [SAMPLE_W:0] mid_sum;

	assign mid_sum = {pend_reg[SAMPLE_W-1], pend_reg}
		+ {i_sample[SAMPLE_W-1], i_sample};

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			pend_reg <= '0;
			interp_reg <= '0;
			half_cnt_reg <= 32'h0;
			half_run_reg <= 1'b0;
		end else if (i_sample_valid) begin
			interp_reg <= mid_sum[SAMPLE_W:1];
			pend_reg <= i_sample;
			half_cnt_reg <= HALF_SAMPLE - 32'h1;
			half_run_reg <= 1'b1;
		end else if (half_run_reg) begin
			if (half_cnt_reg == 32'h0) begin
				interp_reg <= pend_reg;
				half_run_reg <= 1'b0;
			end else begin
				half_cnt_reg <= half_cnt_reg - 32'h1;
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_accel_data <= '0;
			o_accel_valid <= 1'b0;
		end else begin
			o_accel_valid <= resp_start;
			if (resp_start) begin
				o_accel_data <= interp_reg;
			end
		end
	end

	// offset watch
	logic [31:0] hold_cnt_reg;

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			hold_cnt_reg <= OFFSET_HOLD;
		end else if (hold_cnt_reg != 32'h0) begin
			hold_cnt_reg <= hold_cnt_reg - 32'h1;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_offset_over_range <= 1'b0;
		end else if (i_self_test) begin
			o_offset_over_range <= o_offset_over_range;
		end else if (!i_device_config_register.offset_watch_enable
				|| hold_cnt_reg != 32'h0) begin
			o_offset_over_range <= 1'b0;
		end else if (i_offset_update) begin
			o_offset_over_range <=
				($signed(i_offset_corr) > $signed(i_offset_limit.pos))
				|| ($signed(i_offset_corr) < $signed(i_offset_limit.neg));
		end
	end

	// arming evaluation
	aaom_pkg::aaom_arm_mode_t mode;
	logic [3:0] k;
	logic error_hold_reg;
	logic eval;
	logic [SAMPLE_W-1:0] hist_reg [0:6];
	logic [3:0] count_reg;
	logic [3:0] count_next;
	logic cond_reg;
	logic cond_next;
	logic signed [SUM_W-1:0] sum;
	logic signed [SUM_W-1:0] avg;

	assign mode = i_device_config_register.arm_mode;
	assign k = window_k(i_arm_config_register.arm_window_size);
	assign eval = resp_start & ~error_hold_reg;

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			error_hold_reg <= 1'b0;
		end else if (i_arm_error) begin
			error_hold_reg <= 1'b1;
		end
	end

	always_comb begin
		sum = SUM_W'($signed(interp_reg));
		for (int i = 0; i < 7; i++) begin
			if (4'(i + 1) < k) begin
				sum = sum + SUM_W'($signed(hist_reg[i]));
			end
		end
		avg = sum >>> i_arm_config_register.arm_window_size;
	end

	always_comb begin
		count_next = arm_count_next(count_reg, interp_reg,
			i_arm_threshold_register);
		cond_next = 1'b0;
		case (mode)
			aaom_pkg::AAOM_ARM_AVERAGE: begin
				cond_next = beyond(avg[SAMPLE_W-1:0], i_arm_threshold_register);
			end
			aaom_pkg::AAOM_ARM_COUNT: begin
				cond_next = (count_next >= k);
			end
			aaom_pkg::AAOM_ARM_UNFILTERED: begin
				cond_next = beyond(interp_reg, i_arm_threshold_register);
			end
			default: begin
				cond_next = 1'b0;
			end
		endcase
	end

	// saturates rather than wraps so a long run cannot drop the condition
	function automatic logic [3:0] arm_count_next(input logic [3:0] c,
			input logic [SAMPLE_W-1:0] s,
			input aaom_pkg::aaom_arm_thr_t thr);
		if (!beyond(s, thr)) begin
			arm_count_next = aaom_pkg::ARM_COUNT_RESET;
		end else if (c == 4'hF) begin
			arm_count_next = c;
		end else begin
			arm_count_next = c + 4'h1;
		end
	endfunction

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			for (int i = 0; i < 7; i++) begin
				hist_reg[i] <= '0;
			end
			count_reg <= aaom_pkg::ARM_COUNT_RESET;
			cond_reg <= 1'b0;
		end else if (eval) begin
			hist_reg[0] <= interp_reg;
			for (int i = 1; i < 7; i++) begin
				hist_reg[i] <= hist_reg[i-1];
			end
			count_reg <= (mode == aaom_pkg::AAOM_ARM_COUNT)
				? count_next : aaom_pkg::ARM_COUNT_RESET;
			cond_reg <= cond_next;
		end
	end

	// pulse stretch on a free-running timebase
	logic [7:0] tick_cnt_reg;
	logic tick;
	logic [15:0] stretch_reg;
	logic stretch_on;

	assign tick = (tick_cnt_reg == 8'h0);
	assign stretch_on = (i_arm_config_register.arm_stretch_select != 2'h0)
		&& (mode == aaom_pkg::AAOM_ARM_AVERAGE
		|| mode == aaom_pkg::AAOM_ARM_COUNT);

	always_ff @(posedge i_clock) begin
		if (i_srst || tick) begin
			tick_cnt_reg <= 8'(aaom_pkg::STRETCH_TICK_CYCLES - 1);
		end else begin
			tick_cnt_reg <= tick_cnt_reg - 8'h1;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			stretch_reg <= aaom_pkg::STRETCH_RESET;
		end else if (eval && cond_next && stretch_on) begin
			stretch_reg <= stretch_load(
				i_arm_config_register.arm_stretch_select);
		end else if (tick && stretch_reg != 16'h0) begin
			stretch_reg <= stretch_reg - 16'h1;
		end
	end

	logic arm_level;

	always_comb begin
		case (mode)
			aaom_pkg::AAOM_ARM_UNFILTERED: begin
				arm_level = cond_reg & resp_active_reg & ~cs_s2_reg;
			end
			aaom_pkg::AAOM_ARM_AVERAGE, aaom_pkg::AAOM_ARM_COUNT: begin
				arm_level = stretch_on ? (stretch_reg != 16'h0)
					: cond_reg;
			end
			default: begin
				arm_level = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_arm <= 1'b0;
		end else begin
			o_arm <= arm_level ^ i_device_config_register.arm_active_low;
		end
	end

	// pulse-code output: fractional strobe averages 8 MHz from 100 MHz
	logic [6:0] rate_acc_reg;
	logic [7:0] rate_sum;
	logic pcm_tick;
	logic [8:0] pcm_acc_reg;
	logic [9:0] pcm_sum;

	assign rate_sum = {1'b0, rate_acc_reg} + 8'(aaom_pkg::PCM_RATE_MHZ);
	assign pcm_tick = (rate_sum >= 8'(aaom_pkg::CLK_RATE_MHZ));
	// offset binary of the upper nine bits
	assign pcm_sum = {1'b0, pcm_acc_reg}
		+ {1'b0, ~interp_reg[SAMPLE_W-1], interp_reg[SAMPLE_W-2 -: 8]};

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			rate_acc_reg <= 7'h0;
		end else if (pcm_tick) begin
			rate_acc_reg <= 7'(rate_sum - 8'(aaom_pkg::CLK_RATE_MHZ));
		end else begin
			rate_acc_reg <= rate_sum[6:0];
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			pcm_acc_reg <= 9'h000;
			o_pcm <= 1'b0;
		end else if (!i_device_config_register.pcm_enable) begin
			pcm_acc_reg <= 9'h000;
			o_pcm <= 1'b0;
		end else if (pcm_tick) begin
			pcm_acc_reg <= pcm_sum[8:0];
			o_pcm <= pcm_sum[9];
		end
	end

endmodule

/* File: dv/aaom_monitor_properties.sv */
// port checks for the arming/offset monitor
// assumes one core clock domain and the hold-off count handed on by bind
module aaom_monitor_properties #(
	parameter int unsigned OFFSET_HOLD = 200
) (
	input wire logic i_clock,
	input wire logic i_srst,
	input wire logic i_spi_cs_n,
	input wire logic [9:0] i_offset_corr,
	input wire logic i_offset_update,
	input wire logic i_self_test,
	input wire aaom_pkg::aaom_offset_limit_t i_offset_limit,
	input wire aaom_pkg::aaom_dev_cfg_t i_device_config_register,
	input wire logic i_arm_error,
	input wire logic o_accel_valid,
	input wire logic o_offset_over_range,
	input wire logic o_arm
);
	int unsigned hold_cnt_reg;
	logic err_reg;
	logic beyond;
	logic unf;
	assign beyond = $signed(i_offset_corr) > $signed(i_offset_limit.pos) ||
		$signed(i_offset_corr) < $signed(i_offset_limit.neg);
	assign unf = i_device_config_register.arm_mode ==
		aaom_pkg::AAOM_ARM_UNFILTERED;
	// margin of a few cycles: the exact end of hold-off is the design's choice
	always_ff @(posedge i_clock) begin
		if (i_srst)
			hold_cnt_reg <= 0;
		else if (hold_cnt_reg < OFFSET_HOLD + 8)
			hold_cnt_reg <= hold_cnt_reg + 1;
	end
	always_ff @(posedge i_clock) begin
		if (i_srst)
			err_reg <= 1'b0;
		else if (i_arm_error)
			err_reg <= 1'b1;
	end
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_srst);
	sequence s_cs_idle;
		(i_spi_cs_n && unf && $stable(i_device_config_register))[*5];
	endsequence
	sequence s_err_run;
		(err_reg && !unf) ##1 $stable(i_device_config_register);
	endsequence
	property p_valid_pulse;
		o_accel_valid |=> !o_accel_valid;
	endproperty
	property p_valid_cs;
		o_accel_valid |-> !$past(i_spi_cs_n, 3);
	endproperty
	property p_hold;
		hold_cnt_reg < OFFSET_HOLD - 1 |-> !o_offset_over_range;
	endproperty
	property p_value;
		i_offset_update && !i_self_test && hold_cnt_reg > OFFSET_HOLD + 2
		|=> o_offset_over_range == ($past(beyond) &&
		$past(i_device_config_register.offset_watch_enable));
	endproperty
	property p_freeze;
		i_self_test |=> $stable(o_offset_over_range);
	endproperty
	property p_unfilt;
		s_cs_idle |-> o_arm == i_device_config_register.arm_active_low;
	endproperty
	property p_polarity;
		!$past(i_srst) && $past(i_device_config_register.arm_mode) ==
		aaom_pkg::AAOM_ARM_OFF
		|-> o_arm == $past(i_device_config_register.arm_active_low);
	endproperty
	property p_err;
		s_err_run |-> o_arm == $past(o_arm) ||
		o_arm == i_device_config_register.arm_active_low;
	endproperty
	a_valid_pulse: assert property (p_valid_pulse)
		else $error("accel valid longer than one cycle");
	a_valid_cs: assert property (p_valid_cs)
		else $error("accel valid without chip select low");
	a_hold: assert property (p_hold)
		else $error("offset flag during hold-off");
	a_value: assert property (p_value)
		else $error("offset flag wrong after update");
	a_freeze: assert property (p_freeze)
		else $error("offset flag moved in self-test");
	a_unfilt: assert property (p_unfilt)
		else $error("unfiltered arm outside frame");
	a_polarity: assert property (p_polarity)
		else $error("idle arm level wrong");
	a_err: assert property (p_err)
		else $error("arm activated after exception");
endmodule
bind aaom_monitor aaom_monitor_properties #(.OFFSET_HOLD(OFFSET_HOLD))
	i_aaom_monitor_properties (
	.i_clock(i_clock), .i_srst(i_srst), .i_spi_cs_n(i_spi_cs_n),
	.i_offset_corr(i_offset_corr), .i_offset_update(i_offset_update),
	.i_self_test(i_self_test), .i_offset_limit(i_offset_limit),
	.i_device_config_register(i_device_config_register),
	.i_arm_error(i_arm_error), .o_accel_valid(o_accel_valid),
	.o_offset_over_range(o_offset_over_range), .o_arm(o_arm)
);

/* File: dv/aaom_spi_master.sv */
// serial master model: mode 0, MSB first, 48 ns clock only while xfer runs, also with chip select high when sel is low
// assumes the caller picks the gap after each frame
module aaom_spi_master (
	output logic o_sclk,
	output logic o_cs_n,
	output logic o_mosi
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b0;
		o_mosi = 1'b0;
		// a rising select edge puts the link counters into a known state
		#1 o_cs_n = 1'b1;
	end
	// sel low clocks with chip select high, traffic meant for another slave
	task automatic xfer(input logic [15:0] w, input logic sel, input int gap);
		o_cs_n = !sel;
		for (int i = 15; i >= 0; i--) begin
			o_mosi = w[i];
			#24 o_sclk = 1'b1;
			#24 o_sclk = 1'b0;
		end
		#7 o_cs_n = 1'b1;
		// released line shows the inverse, not a stale bit
		o_mosi = ~o_mosi;
		#(gap);
	endtask
endmodule

/* File: dv/aaom_monitor_bench.sv */
// self-checking bench for the arming/offset monitor
// assumes the serial master model and the bound checker are compiled first
module aaom_monitor_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic srst = 1'b0;
	logic [9:0] smp = '0;
	logic smp_v = 1'b0;
	logic [9:0] corr = '0;
	logic upd = 1'b0;
	logic st = 1'b0;
	logic err = 1'b0;
	aaom_pkg::aaom_offset_limit_t lim = {10'h040, 10'h3C0};
	aaom_pkg::aaom_dev_cfg_t dev = '0;
	aaom_pkg::aaom_arm_cfg_t armc = '0;
	aaom_pkg::aaom_arm_thr_t thr = {8'h20, 8'hE0};
	logic sclk, cs_n, mosi, vld, ovr, arm, pcm;
	logic [9:0] data;
	logic [9:0] p;
	int error_cnt = 0;
	int checked = 0;
	int seed = 32'h7540;
	int vcnt = 0;
	int cyc = 0;
	int vcyc, c, v0;
	logic [9:0] s_tab [14] = '{10'h0A0, 10'h3F0, 10'h300, 10'h010, 10'h0A0,
		10'h0A0, 10'h0A0, 10'h0A0, 10'h010, 10'h000, 10'h000, 10'h078,
		10'h090, 10'h000};
	bit a_tab [14] = '{1, 0, 1, 0, 0, 0, 0, 1, 0, 0, 0, 0, 1, 0};
	aaom_monitor #(.OFFSET_HOLD(200), .HALF_SAMPLE(40)) i_aaom_monitor (
		.i_clock(clk), .i_srst(srst), .i_spi_sclk(sclk), .i_spi_cs_n(cs_n),
		.i_spi_mosi(mosi), .i_sample(smp), .i_sample_valid(smp_v),
		.i_offset_corr(corr), .i_offset_update(upd), .i_self_test(st),
		.i_offset_limit(lim), .i_device_config_register(dev),
		.i_arm_config_register(armc), .i_arm_threshold_register(thr),
		.i_arm_error(err), .o_accel_data(data), .o_accel_valid(vld),
		.o_offset_over_range(ovr), .o_arm(arm), .o_pcm(pcm)
	);
	aaom_spi_master i_aaom_spi_master (.o_sclk(sclk), .o_cs_n(cs_n),
		.o_mosi(mosi));
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (vld === 1'b1)
			vcnt <= vcnt + 1;
	end
	task automatic complete_run;
		$display("checked %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t bit %b exp %b", $time, got, exp);
		end
	endtask
	task automatic chk_val(input logic [9:0] got, input logic [9:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t data %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	function automatic logic lvl(input bit a);
		return a ^ dev.arm_active_low;
	endfunction
	function automatic logic ovr_exp(input logic [9:0] v);
		return $signed(v) > $signed(lim.pos) || $signed(v) < $signed(lim.neg);
	endfunction
	task automatic put_smp(input logic [9:0] s);
		smp = s;
		smp_v = 1'b1;
		tick(1);
		smp_v = 1'b0;
	endtask
	task automatic upd_corr(input logic [9:0] v);
		corr = v;
		upd = 1'b1;
		tick(1);
		upd = 1'b0;
	endtask
	task automatic frame(input logic [15:0] w, input logic sel);
		// sub-cycle offset keeps the link clock out of step with clk
		#(0.1 * ($random(seed) & 31));
		i_aaom_spi_master.xfer(w, sel, 100 + ($random(seed) & 255));
	endtask
	// response frame that also carries the next request
	task automatic acc(input logic [9:0] s, input int w, input logic [9:0] ed,
		input bit mid, input bit post);
		int n;
		put_smp(s);
		tick(w);
		v0 = vcnt;
		fork
			frame(16'h8000, 1'b1);
			begin
				for (n = 0; n < 300 && vcnt == v0; n++)
					tick(1);
				if (vcnt == v0) begin
					error_cnt++;
					$display("[ERR] %0t no accel valid", $time);
					complete_run();
				end else begin
					vcyc = cyc;
					chk_val(data, ed);
					tick(3);
					chk_bit(arm, lvl(mid));
				end
			end
		join
		tick(8);
		chk_bit(arm, lvl(post));
	endtask
	initial begin
		dev.offset_watch_enable = 1'b1;
		dev.arm_active_low = 1'($random(seed));
		// a rising reset edge is what clears the link toggle
		#1 srst = 1'b1;
		repeat (16) @(posedge clk);
		tick(1);
		srst = 1'b0;
		tick(1);
		chk_bit(arm, lvl(0));
		upd_corr(10'h100);
		chk_bit(ovr, 1'b0);
		tick(210);
		upd_corr(10'h040);
		chk_bit(ovr, 1'b0);
		for (int i = 0; i < 12; i++) begin
			upd_corr(10'($random(seed)));
			chk_bit(ovr, ovr_exp(corr));
		end
		upd_corr(10'h050);
		st = 1'b1;
		upd_corr(10'h000);
		chk_bit(ovr, 1'b1);
		st = 1'b0;
		dev.offset_watch_enable = 1'b0;
		upd_corr(10'h050);
		chk_bit(ovr, 1'b0);
		$display("offset test done");
		frame(16'h8000, 1'b1);
		p = 10'($random(seed));
		acc(p, 60, p, 0, 0);
		p = 10'($random(seed)) & 10'h0FF;
		put_smp(p);
		tick(60);
		acc(p + 10'h020, 3, p + 10'h010, 0, 0);
		frame(16'h0000, 1'b1);
		frame(16'h8000, 1'b0);
		v0 = vcnt;
		frame(16'h0000, 1'b1);
		tick(8);
		chk_bit(vcnt == v0, 1'b1);
		$display("data test done");
		frame(16'h8000, 1'b1);
		for (int i = 0; i < 14; i++) begin
			dev.arm_mode = i < 3 ? aaom_pkg::AAOM_ARM_UNFILTERED :
				i < 9 ? aaom_pkg::AAOM_ARM_COUNT : aaom_pkg::AAOM_ARM_AVERAGE;
			armc.arm_window_size = i < 9 ? 2'h2 : 2'h1;
			acc(s_tab[i], 60, s_tab[i], a_tab[i], a_tab[i] && i > 2);
		end
		$display("arming test done");
		dev.pcm_enable = 1'b1;
		for (int i = 0; i < 3; i++) begin
			if (i == 2)
				dev.pcm_enable = 1'b0;
			put_smp(i == 1 ? 10'h1FE : 10'h200);
			tick(200);
			c = 0;
			repeat (400) begin
				tick(1);
				c += pcm === 1'b1;
			end
			chk_bit(c > 0, i == 1);
		end
		$display("pcm test done");
		dev.arm_mode = aaom_pkg::AAOM_ARM_COUNT;
		armc = {2'h0, 2'h1};
		acc(10'h010, 60, 10'h010, 0, 0);
		acc(10'h0A0, 60, 10'h0A0, 1, 1);
		c = vcyc;
		err = 1'b1;
		put_smp(10'h0A0);
		// a reload here would push expiry past the second check
		tick(3000);
		frame(16'h8000, 1'b1);
		tick(c + 50000 - cyc);
		chk_bit(arm, lvl(1));
		tick(2500);
		chk_bit(arm, lvl(0));
		$display("stretch test done");
		srst = 1'b1;
		tick(2);
		chk_bit(arm | ovr | vld | pcm, 1'b0);
		srst = 1'b0;
		err = 1'b0;
		tick(2);
		chk_bit(arm, lvl(0));
		complete_run();
	end
endmodule
